// *** spirsp_core.sv ***
// serial peripheral responder port with checksum, buffers, wake and watchdog
`timescale 1ns/1ns

module spirsp_degl #(
    parameter int N = 4,
    parameter logic INIT = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic d_i,
    input wire logic en_i,
    output logic q_o
);
    logic s1_r, s2_r, s3_r, kept_r, q_r;
    logic [7:0] cnt_r;
    generate
        if (N < 1 || N > 255) begin : g_chk
            $error("deglitch length out of range");
        end
    endgenerate
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_r <= INIT;
            s2_r <= INIT;
            s3_r <= INIT;
        end else begin
            s1_r <= d_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    // with en_i set, value passes only after it has held for N cycles; with en_i clear it passes straight through
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r <= 8'h00;
            kept_r <= INIT;
            q_r <= INIT;
        end else begin
            if (s2_r != s3_r) begin
                cnt_r <= 8'h00;
            end else if (cnt_r != 8'(N)) begin
                cnt_r <= cnt_r + 8'h01;
            end
            if (s2_r == s3_r && cnt_r == 8'(N)) begin
                kept_r <= s2_r;
            end
            q_r <= en_i ? kept_r : s2_r;
        end
    end
    assign q_o = q_r;
endmodule

// Functional notes
// RULE_01 - clock idles low, data sampled on the first (rising) clock edge.
// RULE_02 - a frame is sixteen clocks, or twenty-four with checksum on.
// RULE_03 - checksum is CRC-8 polynomial 0x07, enabled by configuration.
// RULE_04 - wrong clock count or bad checksum marks the frame in error.
// RULE_05 - bad checksum: drop input, next reply is 0xffff then 0xaa.
// RULE_06 - oscillator not ready at frame start: reply all ones.
// RULE_07 - chip select fall wakes oscillator; usable after settling time.
// RULE_08 - oscillator held for idle seconds after wake, at least one second.
// RULE_09 - host leaves fifty microseconds between frames.
// RULE_10 - chip select low with frozen clock two seconds resets the port.
// RULE_11 - output supply selection applies only after the switch command; the port also takes it once after reset.
// RULE_12 - each input passes a deglitch filter, enabled unless configured off.
// RULE_13 - first byte: direction bit then seven-bit address, msb first.
// RULE_14 - second byte is write data; ignored for reads except checksum.
// RULE_15 - third byte is checksum; input accepted only if it matches.
// RULE_16 - frame shifts out buffer; stale buffer returns 0xffff and 0x00.
// RULE_17 - consumed write is echoed through the outgoing buffer.
// RULE_18 - read reply loaded by internal logic; port computes its checksum.
// RULE_19 - all-ones first two bytes are never a legitimate transaction.
// RULE_20 - subcommand buffer reads before loading return stale pattern.
// RULE_21 - host retries on all-ones, checksum error or stale pattern.
// RULE_22 - protocol choice applies at reset or switch command only.
// RULE_23 - checksum starts at zero each frame, msb first as on wire.
// RULE_24 - input sampled on rising clock, output changes on falling.
module spirsp_core import spirsp_pkg::*; #(
    parameter int WDOG_CYCLES = WDOG_CYC,
    parameter int SEC_CYCLES = SEC_CYC,
    parameter int SETTLE_CYCLES = OSC_SETTLE_CYC,
    parameter int DEGL_CYCLES = DEGLITCH_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic mosi_i,
    output logic miso_o,
    output logic miso_oe_n_o,
    input wire logic cfg_serial_sel_i,
    input wire logic cfg_crc_en_i,
    input wire logic cfg_output_supply_select_i,
    input wire logic switch_to_serial_peripheral_i,
    input wire logic input_deglitch_enable_i,
    input wire logic [7:0] comm_idle_time_i,
    input wire logic tx_load_i,
    input wire spirsp_word_t tx_word_i,
    output logic rx_valid_o,
    output spirsp_word_t rx_word_o,
    output logic frame_err_o,
    output logic crc_err_o,
    output logic wdog_rst_o,
    output logic fast_internal_oscillator_en_o,
    output logic port_en_o,
    output logic crc_mode_o,
    output logic output_supply_select_o
);
    generate
        if (WDOG_CYCLES < 2 || WDOG_CYCLES >= 2**26 || SEC_CYCLES < 2 || SEC_CYCLES >= 2**25
            || SETTLE_CYCLES < 1 || SETTLE_CYCLES >= 2**16) begin : g_chk
            $error("timing parameter out of range");
        end
    endgenerate

    function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
        crc_step = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? CRC_POLY : 8'h00);
    endfunction
    function automatic logic [7:0] crc_word(input logic [15:0] w);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            c = crc_step(c, w[i]);
        end
        crc_word = c;
    endfunction

    logic sclk_f, cs_n_f, mosi_f, sclk_d_r, cs_n_d_r;
    logic init_r, in_frame_r, dead_r, fresh_r, osc_ready_r;
    logic rx_valid_r, frame_err_r, crc_err_r, wdog_r, osc_en_r, oe_n_r;
    logic port_en_r, crc_mode_r, supply_r;
    logic [4:0] bit_cnt_r;
    logic [23:0] rx_sh_r, sh_out_r;
    logic [7:0] crc_r, tx_crc_r, hold_s_r;
    logic [15:0] tx_buf_r, settle_r;
    logic [25:0] wdog_cnt_r;
    logic [24:0] presc_r;
    spirsp_word_t rx_word_r;

    // RULE_12
    spirsp_degl #(.N(DEGL_CYCLES), .INIT(1'b0)) u_f_sclk (.clk_i(clk_i), .rst_i(rst_i), .d_i(sclk_i),
        .en_i(input_deglitch_enable_i), .q_o(sclk_f));
    spirsp_degl #(.N(DEGL_CYCLES), .INIT(1'b1)) u_f_cs (.clk_i(clk_i), .rst_i(rst_i), .d_i(cs_n_i),
        .en_i(input_deglitch_enable_i), .q_o(cs_n_f));
    spirsp_degl #(.N(DEGL_CYCLES), .INIT(1'b0)) u_f_mosi (.clk_i(clk_i), .rst_i(rst_i), .d_i(mosi_i),
        .en_i(input_deglitch_enable_i), .q_o(mosi_f));

    logic sclk_rise, sclk_fall, cs_fall, cs_rise, start, frame_end, wdog_hit;
    logic len_ok, crc_ok, good;
    logic [15:0] rx_pair;
    assign sclk_rise = sclk_f & ~sclk_d_r;
    assign sclk_fall = ~sclk_f & sclk_d_r;
    assign cs_fall = ~cs_n_f & cs_n_d_r;
    assign cs_rise = cs_n_f & ~cs_n_d_r;
    assign start = cs_fall & port_en_r;
    assign frame_end = cs_rise & in_frame_r;
    assign wdog_hit = in_frame_r && wdog_cnt_r == 26'(WDOG_CYCLES - 1);
    assign len_ok = bit_cnt_r == (crc_mode_r ? FRAME_CRC_BITS : FRAME_BITS); // RULE_02
    assign rx_pair = crc_mode_r ? rx_sh_r[23:8] : rx_sh_r[15:0];
    assign crc_ok = rx_sh_r[7:0] == crc_r; // RULE_15
    assign good = frame_end & ~dead_r & len_ok & (~crc_mode_r | crc_ok);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sclk_d_r <= 1'b0;
            cs_n_d_r <= 1'b1;
        end else begin
            sclk_d_r <= sclk_f;
            cs_n_d_r <= cs_n_f;
        end
    end

    // settings are taken once after reset and again only on the switch command
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            init_r <= 1'b1;
            port_en_r <= 1'b0;
            crc_mode_r <= 1'b0;
            supply_r <= 1'b0;
        end else begin
            init_r <= 1'b0;
            if (init_r || switch_to_serial_peripheral_i) begin
                port_en_r <= init_r ? cfg_serial_sel_i : 1'b1; // RULE_22
                crc_mode_r <= cfg_crc_en_i; // RULE_03
                supply_r <= cfg_output_supply_select_i; // RULE_11
            end
        end
    end

    // frame shifting; mode 0: sample on rise, shift out on fall
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            in_frame_r <= 1'b0;
            dead_r <= 1'b0;
            bit_cnt_r <= 5'h00;
            rx_sh_r <= 24'h000000;
            crc_r <= CRC_INIT;
            sh_out_r <= 24'hffffff;
            oe_n_r <= 1'b1;
        end else if (wdog_hit) begin
            in_frame_r <= 1'b0; // RULE_10
            bit_cnt_r <= 5'h00;
            oe_n_r <= 1'b1;
        end else if (start) begin
            in_frame_r <= 1'b1;
            oe_n_r <= 1'b0;
            bit_cnt_r <= 5'h00;
            crc_r <= CRC_INIT; // RULE_23
            dead_r <= ~osc_ready_r;
            if (!osc_ready_r) begin
                sh_out_r <= {ERR_WORD, OSC_OFF_CODE}; // RULE_06
            end else if (fresh_r) begin
                sh_out_r <= {tx_buf_r, tx_crc_r}; // RULE_16
            end else begin
                sh_out_r <= {ERR_WORD, STALE_CODE}; // RULE_16
            end
        end else if (in_frame_r) begin
            if (sclk_rise) begin
                rx_sh_r <= {rx_sh_r[22:0], mosi_f}; // RULE_01 RULE_24 RULE_13
                if (bit_cnt_r != 5'h1f) begin
                    bit_cnt_r <= bit_cnt_r + 5'h01;
                end
                if (bit_cnt_r < FRAME_BITS) begin
                    crc_r <= crc_step(crc_r, mosi_f); // RULE_14 RULE_23
                end
            end
            if (sclk_fall && bit_cnt_r != 5'h00) begin
                sh_out_r <= {sh_out_r[22:0], 1'b1}; // RULE_24
            end
            if (cs_rise) begin
                in_frame_r <= 1'b0;
                oe_n_r <= 1'b1;
            end
        end
    end

    // end of frame verdict; frames seen with the oscillator off are dropped
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_valid_r <= 1'b0;
            rx_word_r <= '0;
            frame_err_r <= 1'b0;
            crc_err_r <= 1'b0;
            wdog_r <= 1'b0;
        end else begin
            frame_err_r <= frame_end & ~dead_r & ~len_ok; // RULE_04
            crc_err_r <= frame_end & ~dead_r & len_ok & crc_mode_r & ~crc_ok; // RULE_04
            rx_valid_r <= good & (rx_pair != ERR_WORD); // RULE_19
            wdog_r <= wdog_hit;
            if (good) begin
                rx_word_r <= rx_pair;
            end
        end
    end

    // outgoing buffer; a load or error in the start cycle beats the stale clear
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_buf_r <= ERR_WORD;
            tx_crc_r <= STALE_CODE;
            fresh_r <= 1'b0;
        end else if (frame_end & ~dead_r & len_ok & crc_mode_r & ~crc_ok) begin
            tx_buf_r <= ERR_WORD; // RULE_05
            tx_crc_r <= CRC_ERR_CODE;
            fresh_r <= 1'b1;
        end else if (tx_load_i) begin
            tx_buf_r <= tx_word_i; // RULE_17 RULE_18
            tx_crc_r <= crc_word(tx_word_i); // RULE_18
            fresh_r <= 1'b1;
        end else if (start && osc_ready_r) begin
            fresh_r <= 1'b0; // RULE_20
        end
    end

    // bus freeze watchdog counts cycles without a clock edge while selected
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wdog_cnt_r <= 26'h0000000;
        end else if (!in_frame_r || sclk_rise || sclk_fall || wdog_hit) begin
            wdog_cnt_r <= 26'h0000000;
        end else begin
            wdog_cnt_r <= wdog_cnt_r + 26'h0000001; // RULE_10
        end
    end

    // oscillator wake and hold; a held oscillator costs supply current
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            osc_en_r <= 1'b0;
            hold_s_r <= 8'h00;
            presc_r <= 25'h0000000;
        end else if (start) begin
            osc_en_r <= 1'b1; // RULE_07
            hold_s_r <= (comm_idle_time_i == 8'h00) ? HOLD_MIN : comm_idle_time_i; // RULE_08
            presc_r <= 25'h0000000;
        end else if (osc_en_r) begin
            if (presc_r == 25'(SEC_CYCLES - 1)) begin
                presc_r <= 25'h0000000;
                if (hold_s_r != 8'h00) begin
                    hold_s_r <= hold_s_r - 8'h01;
                end
            end else begin
                presc_r <= presc_r + 25'h0000001;
            end
            if (hold_s_r == 8'h00 && !in_frame_r) begin
                osc_en_r <= 1'b0; // RULE_08
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            settle_r <= 16'h0000;
            osc_ready_r <= 1'b0;
        end else if (!osc_en_r) begin
            settle_r <= 16'h0000;
            osc_ready_r <= 1'b0;
        end else if (settle_r == 16'(SETTLE_CYCLES - 1)) begin
            osc_ready_r <= 1'b1; // RULE_07
        end else begin
            settle_r <= settle_r + 16'h0001;
        end
    end

    assign miso_o = sh_out_r[23];
    assign miso_oe_n_o = oe_n_r;
    assign rx_valid_o = rx_valid_r;
    assign rx_word_o = rx_word_r;
    assign frame_err_o = frame_err_r;
    assign crc_err_o = crc_err_r;
    assign wdog_rst_o = wdog_r;
    assign fast_internal_oscillator_en_o = osc_en_r;
    assign port_en_o = port_en_r;
    assign crc_mode_o = crc_mode_r;
    assign output_supply_select_o = supply_r;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_crc_err_pattern: assert property (crc_err_r |-> tx_buf_r == 16'hffff && tx_crc_r == 8'haa) // RULE_05
        else $error("checksum error pattern not loaded");
    a_osc_off_ones: assert property (start && !osc_ready_r |=> sh_out_r == 24'hffffff) // RULE_06
        else $error("oscillator-off reply not all ones");
    a_stale_reply: assert property (start && osc_ready_r && !fresh_r |=> sh_out_r == 24'hffff00) // RULE_16
        else $error("stale reply pattern wrong");
    a_frame_length: assert property (frame_end && !dead_r && bit_cnt_r == 5'h11 && !crc_mode_r // RULE_04
        |=> frame_err_r && !rx_valid_r)
        else $error("bad clock count not flagged");
    a_wdog_clear: assert property (wdog_hit |=> !in_frame_r && bit_cnt_r == 5'h00 ##0 wdog_rst_o) // RULE_10
        else $error("watchdog did not reset port");
    a_wake_osc: assert property (start |=> osc_en_r ##1 !osc_ready_r || $past(osc_ready_r, 2)) // RULE_07
        else $error("chip select did not wake oscillator");
    a_never_ones: assert property (rx_valid_o |-> rx_word_o != 16'hffff) // RULE_19
        else $error("all-ones word delivered");
    a_echo_load: assert property (tx_load_i |=> crc_err_r || (fresh_r && tx_buf_r == $past(tx_word_i) // RULE_17
        && tx_crc_r == crc_word($past(tx_word_i))))
        else $error("outgoing buffer not loaded");
    a_mode_hold: assert property (!init_r && !switch_to_serial_peripheral_i |=> $stable(crc_mode_r) // RULE_22
        && $stable(supply_r))
        else $error("mode changed without switch");
    a_miso_hold: assert property (in_frame_r && !sclk_fall && !start && !wdog_hit |=> $stable(miso_o)) // RULE_24
        else $error("output changed off a falling edge");
endmodule

// *** spirsp_host.sv ***
// host controller model that drives the responder pins in clock mode 0
`timescale 1ns/1ns
module spirsp_host (
    output logic sclk_o,
    output logic cs_n_o,
    output logic mosi_o,
    input wire logic miso_i,
    output logic [24:0] rep_o,
    output logic rep_ev_o
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
        rep_o = '0;
        rep_ev_o = 1'b0;
    end
    // miso is taken late in the high phase: the responder output trails the pins by sync and filter delay
    task automatic xfer(input int n, input logic [24:0] d, input int half);
        logic [24:0] r;
        r = '0;
        #7;
        cs_n_o = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            mosi_o = d[i];
            #(half);
            sclk_o = 1'b1;
            #(half - 5);
            r = {r[23:0], miso_i};
            #5;
            sclk_o = 1'b0;
        end
        #(half);
        cs_n_o = 1'b1;
        mosi_o = ~mosi_o;
        rep_o = r;
        rep_ev_o = 1'b1;
        #(half);
        rep_ev_o = 1'b0;
        #50_000;
    endtask
    // selects the responder and then leaves the clock frozen
    task automatic hang(input int t);
        #7;
        cs_n_o = 1'b0;
        #(t);
        cs_n_o = 1'b1;
        #50_000;
    endtask
endmodule

// *** spirsp_pkg.sv ***
// shared constants and types for the serial peripheral responder
package spirsp_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_NS = 50;
    localparam int OSC_SETTLE_NS = 50_000;
    localparam int OSC_SETTLE_CYC = (OSC_SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int DEGLITCH_NS = 200;
    localparam int DEGLITCH_CYC = DEGLITCH_NS / CLK_NS;
    localparam int WDOG_S = 2;
    localparam int WDOG_CYC = WDOG_S * CLK_HZ;
    localparam int HOLD_MIN_S = 1;
    localparam int SEC_CYC = CLK_HZ;
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] FRAME_CRC_BITS = 5'h18;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;
    localparam logic [15:0] ERR_WORD = 16'hffff;
    localparam logic [7:0] CRC_ERR_CODE = 8'haa;
    localparam logic [7:0] STALE_CODE = 8'h00;
    localparam logic [7:0] OSC_OFF_CODE = 8'hff;
    localparam logic [7:0] HOLD_MIN = 8'h01;

    typedef struct packed {
        logic wr;
        logic [6:0] addr;
        logic [7:0] data;
    } spirsp_word_t;
endpackage

// *** test_spirsp_core.sv ***
// self-checking bench for the serial peripheral responder
`timescale 1ns/1ns
module test_spirsp_core import spirsp_pkg::*; ();
    typedef struct packed {
        logic [2:0] k;
        logic [4:0] sh;
        logic [24:0] v;
    } spirsp_exp_t;
    localparam logic [2:0] k_rep = 3'h0;
    localparam logic [2:0] k_rx = 3'h1;
    localparam logic [2:0] k_frm = 3'h2;
    localparam logic [2:0] k_crc = 3'h3;
    localparam logic [2:0] k_wdg = 3'h4;
    localparam logic [2:0] k_none = 3'h7;
    logic clk, rst, sclk, cs_n, mosi, miso, oe_n, crc_en, sup_sel, swp, dgl_en, tx_load, rep_ev, ser_sel;
    logic rx_valid, frame_err, crc_err, wdog, osc_en, port_en, crc_mode, sup_o;
    logic [7:0] idle;
    logic [24:0] rep;
    spirsp_word_t tx_word, rx_word;
    spirsp_exp_t q[$];
    int bad_count = 0;
    int total_checks = 0;

    spirsp_core #(.WDOG_CYCLES(200), .SEC_CYCLES(1000), .SETTLE_CYCLES(20)) dut (
        .clk_i(clk), .rst_i(rst), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso),
        .miso_oe_n_o(oe_n), .cfg_serial_sel_i(ser_sel), .cfg_crc_en_i(crc_en), .cfg_output_supply_select_i(sup_sel),
        .switch_to_serial_peripheral_i(swp), .input_deglitch_enable_i(dgl_en), .comm_idle_time_i(idle),
        .tx_load_i(tx_load), .tx_word_i(tx_word), .rx_valid_o(rx_valid), .rx_word_o(rx_word),
        .frame_err_o(frame_err), .crc_err_o(crc_err), .wdog_rst_o(wdog), .fast_internal_oscillator_en_o(osc_en),
        .port_en_o(port_en), .crc_mode_o(crc_mode), .output_supply_select_o(sup_o));
    spirsp_host host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso), .rep_o(rep), .rep_ev_o(rep_ev));

    function automatic logic [24:0] wc(input logic [15:0] w);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
        return {1'b0, w, c};
    endfunction
    task automatic fail(input string m);
        bad_count++;
        $display("[ERR] %0t %s", $time, m);
    endtask
    task automatic chk(input logic [24:0] got, input logic [24:0] want, input string m);
        total_checks++;
        if (got !== want) fail($sformatf("%s: got %h want %h", m, got, want));
    endtask
    task automatic ex(input logic [2:0] k, input int sh, input logic [24:0] v);
        q.push_back('{k, 5'(sh), v});
    endtask
    // the oldest note must match whatever result shows up next
    task automatic take(input logic [2:0] k, input logic [24:0] v);
        spirsp_exp_t e;
        if (q.size() == 0) begin
            fail($sformatf("unexpected result kind %0d", k));
        end else begin
            e = q.pop_front();
            chk(25'(k), 25'(e.k), "result kind");
            chk(v >> e.sh, e.v, "result value");
        end
    endtask
    task automatic frm(input int n, input logic [24:0] d, input logic [24:0] want, input int sh, input int half,
                       input logic [2:0] vk, input logic [15:0] vv);
        ex(k_rep, sh, want);
        if (vk != k_none) ex(vk, 0, 25'(vv));
        @(posedge clk);
        host.xfer(n, d, half);
    endtask
    task automatic load(input logic [15:0] w);
        @(posedge clk);
        tx_load <= 1'b1;
        tx_word <= w;
        @(posedge clk);
        tx_load <= 1'b0;
    endtask
    task automatic endt(input string name);
        repeat (20) @(posedge clk);
        total_checks++;
        if (q.size() != 0) fail($sformatf("%s: %0d results missing", name, q.size()));
        q.delete();
        $display("test %s done", name);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        if (rx_valid === 1'b1) take(k_rx, 25'(rx_word));
        if (frame_err === 1'b1) take(k_frm, '0);
        if (crc_err === 1'b1) take(k_crc, '0);
        if (wdog === 1'b1) take(k_wdg, '0);
    end
    always @(posedge rep_ev) take(k_rep, rep);

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        #3_000_000;
        fail("run timed out");
        close_out();
    end
    initial begin
        logic [15:0] w;
        logic [15:0] r;
        rst = 1'b1;
        crc_en = 1'b1;
        ser_sel = 1'b1;
        sup_sel = 1'b0;
        swp = 1'b0;
        dgl_en = 1'b0;
        idle = 8'h0a;
        tx_load = 1'b0;
        tx_word = '0;
        void'($urandom(32'h5939));
        // address kept below 0x7f so the word can never be all ones
        w = {1'b1, 7'($urandom % 127), 8'($urandom)};
        r = {1'b0, 7'($urandom), 8'($urandom)};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk(25'({port_en, crc_mode, oe_n}), 25'h7, "settings after reset");
        frm(24, wc(w), 25'hffffff, 0, 200, k_none, 0);
        endt("wake");
        frm(24, wc(w), 25'hffff00, 0, 200, k_rx, w);
        load(w);
        frm(24, wc(r), wc(w), 0, 200, k_rx, r);
        load({r[15:8], 8'h3c});
        frm(24, wc(w), wc({r[15:8], 8'h3c}), 0, 200, k_rx, w);
        frm(24, wc(w), 25'hffff00, 0, 200, k_rx, w);
        endt("echo");
        frm(24, wc(w) ^ 25'h1, 25'hffff00, 0, 200, k_crc, 0);
        frm(24, wc(w), 25'hffffaa, 0, 200, k_rx, w);
        frm(16, 25'(w), 25'hffff, 0, 200, k_frm, 0);
        frm(25, wc(w) << 1, 25'hffff00, 1, 200, k_frm, 0);
        endt("crc_mode");
        @(posedge clk);
        crc_en <= 1'b0;
        sup_sel <= 1'b1;
        repeat (3) @(posedge clk);
        chk(25'({crc_mode, sup_o}), 25'h2, "settings before switch");
        swp <= 1'b1;
        @(posedge clk);
        swp <= 1'b0;
        repeat (2) @(posedge clk);
        chk(25'({crc_mode, sup_o}), 25'h1, "settings after switch");
        frm(16, 25'(w), 25'hffff, 0, 200, k_rx, w);
        load(w);
        frm(17, 25'(w) << 1, 25'(w), 1, 200, k_frm, 0);
        frm(16, 25'hffff, 25'hffff, 0, 200, k_none, 0);
        frm(24, wc(w), 25'hffff, 8, 200, k_frm, 0);
        endt("plain_mode");
        @(posedge clk);
        dgl_en <= 1'b1;
        frm(16, 25'(r), 25'hffff, 0, 400, k_rx, r);
        @(posedge clk);
        dgl_en <= 1'b0;
        ex(k_wdg, 0, 0);
        @(posedge clk);
        host.hang(20_000);
        frm(16, 25'(w), 25'hffff, 0, 200, k_rx, w);
        endt("filter_wdog");
        @(posedge clk);
        idle <= 8'h00;
        fork
            frm(16, 25'(w), 25'hffff, 0, 200, k_rx, w);
            begin
                repeat (600) @(posedge clk);
                chk(25'(osc_en), 25'h1, "oscillator held");
            end
        join
        repeat (200) @(posedge clk);
        chk(25'(osc_en), 25'h0, "oscillator released");
        frm(16, 25'(w), 25'hffff, 0, 200, k_none, 0);
        endt("hold");
        // second reset with the interface deselected: only the switch command opens the port
        @(posedge clk);
        ser_sel <= 1'b0;
        idle <= 8'h0a;
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk(25'({port_en, crc_mode, osc_en, oe_n}), 25'h1, "port closed after reset");
        frm(16, 25'(w), 25'hffff, 0, 200, k_none, 0);
        chk(25'(osc_en), 25'h0, "closed port woke oscillator");
        swp <= 1'b1;
        @(posedge clk);
        swp <= 1'b0;
        repeat (2) @(posedge clk);
        chk(25'({port_en, crc_mode}), 25'h2, "switch did not open port");
        frm(16, 25'(w), 25'hffff, 0, 200, k_none, 0);
        chk(25'(osc_en), 25'h1, "open port did not wake oscillator");
        endt("select");
        close_out();
    end
endmodule
